// >>> design/tx_safety_ctrl.sv
// Transmit safety control: gates bias and modulation, latches faults,
// sequences power-down, reset and initialization.
// Assumes pins are asynchronous; fault_detect comes from logic on clk_sys.
`timescale 1ns/1ps
module tx_safety_ctrl #(
    parameter int SETTLE_CYCLES = tx_safety_pkg::SETTLE_CYCLES,
    parameter int INIT_CYCLES   = tx_safety_pkg::INIT_CYCLES
) (
    input  wire logic clk_sys,
    input  wire logic reset_n,
    input  wire logic clk_en,
    input  wire logic transmit_off_request,
    input  wire logic power_down_request,
    input  wire logic serial_port_select,
    input  wire logic cathode_select,
    input  wire logic fault_detect,
    input  wire logic spi_data_out,
    input  wire logic spi_data_out_en,
    input  wire logic two_wire_data_out_en,
    input  wire logic host_link_pin_a_in,
    input  wire logic host_link_pin_b_in,
    output logic      host_link_pin_a_out,
    output logic      host_link_pin_a_oe,
    output logic      host_link_pin_b_out,
    output logic      host_link_pin_b_oe,
    output logic      two_wire_clock,
    output logic      two_wire_data,
    output logic      spi_data_in,
    output logic      spi_mode,
    output logic      bias_enable,
    output logic      modulation_enable,
    output logic      supply_switch_or_cathode_bias,
    output logic      anode_bias_or_ground_switch,
    output logic      fault_out,
    output logic      fault_oe,
    output logic      power_down,
    output logic      init_reset,
    output logic      output_stable
);

    // -------------------------------------------------------------------
    // Pin synchronizers
    // -------------------------------------------------------------------
    localparam int NSYNC = 6;
    logic [NSYNC-1:0] pins;
    logic [NSYNC-1:0] s1_q, s2_q, s3_q, s1_d, s2_d, s3_d;
    logic [NSYNC-1:0] filt_q, filt_d;

    assign pins = {host_link_pin_b_in, host_link_pin_a_in, cathode_select,
                   serial_port_select, power_down_request, transmit_off_request};

    // Change accepted once second and third stages agree [R15]
    always_comb begin
        s1_d   = pins;
        s2_d   = s1_q;
        s3_d   = s2_q;
        filt_d = filt_q;
        for (int i = 0; i < NSYNC; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                filt_d[i] = s3_q[i];
            end
        end
    end

    // Floating selects read as their pull levels; transmit-off and
    // power-down reset high, the safe state
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s1_q   <= 6'h03;
            s2_q   <= 6'h03;
            s3_q   <= 6'h03;
            filt_q <= 6'h03;
        end else if (clk_en) begin
            s1_q   <= s1_d;
            s2_q   <= s2_d;
            s3_q   <= s3_d;
            filt_q <= filt_d;
        end
    end

    logic txoff, pdrst, spi_sel, cc_sel;
    assign txoff   = filt_q[0];
    assign pdrst   = filt_q[1];
    assign spi_sel = filt_q[2];
    assign cc_sel  = filt_q[3];

    // -------------------------------------------------------------------
    // Safety sequencer
    // -------------------------------------------------------------------
    // Local names for the shared state encoding; the package is never imported
    localparam tx_safety_pkg::state_e ST_INIT  = tx_safety_pkg::ST_INIT;
    localparam tx_safety_pkg::state_e ST_RUN   = tx_safety_pkg::ST_RUN;
    localparam tx_safety_pkg::state_e ST_FAULT = tx_safety_pkg::ST_FAULT;
    localparam tx_safety_pkg::state_e ST_PDOWN = tx_safety_pkg::ST_PDOWN;

    tx_safety_pkg::state_e state_q, state_d;
    logic [tx_safety_pkg::CNT_W-1:0] cnt_q, cnt_d;       // Init / settle timer
    logic [tx_safety_pkg::CNT_W-1:0] txw_q, txw_d;       // Transmit-off width
    logic [tx_safety_pkg::CNT_W-1:0] pdw_q, pdw_d;       // Power-down width
    logic pd_prev_q, pd_prev_d, stable_q, stable_d, flt_q, flt_d;
    logic tx_long, pd_long, pd_fall;

    localparam logic [tx_safety_pkg::CNT_W-1:0] RST_CNT =
        tx_safety_pkg::CNT_W'(tx_safety_pkg::RESET_CYCLES);
    localparam logic [tx_safety_pkg::CNT_W-1:0] PD_CNT =
        tx_safety_pkg::CNT_W'(tx_safety_pkg::PDRST_CYCLES);
    localparam logic [tx_safety_pkg::CNT_W-1:0] SET_CNT =
        tx_safety_pkg::CNT_W'(SETTLE_CYCLES);

    assign tx_long = (txw_q >= RST_CNT);                   // [R5]
    assign pd_long = (pdw_q >= PD_CNT);                    // [R7]
    assign pd_fall = pd_prev_q && !pdrst;

    always_comb begin
        state_d   = state_q;
        cnt_d     = cnt_q;
        stable_d  = stable_q;
        flt_d     = flt_q;
        pd_prev_d = pdrst;
        // Width counters saturate, clear when input is low [R15]
        txw_d = txoff ? (tx_long ? txw_q : txw_q + 1'b1) : '0;
        pdw_d = pdrst ? (pd_long ? pdw_q : pdw_q + 1'b1) : '0;
        unique case (state_q)
            ST_INIT: begin
                // Settle well inside the init limit [R3]
                if (cnt_q >= SET_CNT) begin
                    state_d  = ST_RUN;
                    stable_d = 1'b1;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            ST_RUN: begin
                if (fault_detect) begin
                    state_d = ST_FAULT;                    // [R4]
                end
            end
            ST_FAULT: begin
                // Latched until a long transmit-off pulse [R5]
                if (tx_long) begin
                    state_d  = ST_INIT;
                    cnt_d    = '0;
                    stable_d = 1'b0;
                end
            end
            ST_PDOWN: begin
                stable_d = 1'b0;
            end
        endcase
        if (state_q == ST_FAULT || fault_detect) begin
            flt_d = 1'b1;
        end else if (state_q != ST_FAULT) begin
            flt_d = 1'b0;
        end
        // Power-down overrides everything while held [R6] [R8]
        if (pdrst && pd_long) begin
            state_d  = ST_PDOWN;
            stable_d = 1'b0;
        end else if (pd_fall && state_q == ST_PDOWN) begin
            // Falling edge restarts like power-on [R9]
            state_d  = ST_INIT;
            cnt_d    = '0;
            flt_d    = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q   <= ST_INIT;
            cnt_q     <= '0;
            txw_q     <= '0;
            pdw_q     <= '0;
            pd_prev_q <= 1'b1;
            stable_q  <= 1'b0;
            flt_q     <= 1'b0;
        end else if (clk_en) begin
            state_q   <= state_d;
            cnt_q     <= cnt_d;
            txw_q     <= txw_d;
            pdw_q     <= pdw_d;
            pd_prev_q <= pd_prev_d;
            stable_q  <= stable_d;
            flt_q     <= flt_d;
        end
    end

    // -------------------------------------------------------------------
    // Laser gating and outputs
    // -------------------------------------------------------------------
    logic drive_q, drive_d;
    // Drive only in run and transmit-off low; a few cycles, far under 10 us [R1] [R2] [R10]
    assign drive_d = (state_q == ST_RUN) && !txoff && !fault_detect;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            drive_q <= 1'b0;
        end else if (clk_en) begin
            drive_q <= drive_d;
        end
    end

    assign bias_enable       = drive_q;
    assign modulation_enable = drive_q;
    // Bias and redundant switch both follow the drive; cathode select is unused [R13] [R14]
    assign supply_switch_or_cathode_bias = drive_q;
    assign anode_bias_or_ground_switch   = drive_q;
    assign spi_mode    = spi_sel;                          // [R11]
    assign fault_out   = 1'b0;
    assign fault_oe    = !flt_q;                           // Open collector, release = high [R4]
    assign power_down  = (state_q == ST_PDOWN);
    assign init_reset  = (state_q == ST_INIT) || (state_q == ST_PDOWN);
    assign output_stable = stable_q;

    // Pin role follows the interface select [R12]
    assign two_wire_clock      = spi_sel ? 1'b1 : filt_q[4];
    assign two_wire_data       = spi_sel ? 1'b1 : filt_q[5];
    assign spi_data_in         = spi_sel ? filt_q[5] : 1'b0;
    assign host_link_pin_a_out = spi_sel ? spi_data_out : 1'b0;
    assign host_link_pin_a_oe  = spi_sel ? spi_data_out_en : 1'b0;
    assign host_link_pin_b_out = 1'b0;
    assign host_link_pin_b_oe  = spi_sel ? 1'b0 : two_wire_data_out_en;

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    sequence tx_raised_s;
        $rose(txoff);
    endsequence

    laser_off_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R1]
        clk_en && txoff |=> !bias_enable && !modulation_enable)
        else $error("Laser still driven while transmit-off is high");
    off_fast_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R10]
        tx_raised_s |-> ##[0:4] !modulation_enable)
        else $error("Modulation not switched off after transmit-off rise");
    fault_flag_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R4]
        clk_en && fault_detect |=> !fault_oe)
        else $error("Fault indicator not raised after fault");
    fault_latch_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R5]
        state_q == ST_FAULT && !tx_long && !(pdrst && pd_long) |=> state_q == ST_FAULT)
        else $error("Fault released without a long transmit-off pulse");
    pdown_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R8]
        clk_en && pdrst && pd_long |=> power_down)
        else $error("Power-down not entered while request held");
    pd_short_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R7]
        $rose(power_down) |-> $past(pd_long))
        else $error("Power-down entered before qualification width");
    restart_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R9]
        clk_en && pd_fall && state_q == ST_PDOWN && !pdrst |=> state_q == ST_INIT)
        else $error("No restart after power-down release");
    stable_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R3]
        output_stable |-> state_q != ST_INIT && state_q != ST_PDOWN)
        else $error("Output stable flagged during init or power-down");
    sel_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R11]
        spi_mode == filt_q[2] && (spi_mode || !host_link_pin_a_oe))
        else $error("Host pin role does not follow select");
    drive_on_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R2]
        clk_en && state_q == ST_RUN && !txoff && !fault_detect
        |=> bias_enable && modulation_enable)
        else $error("Laser not restored after transmit-off release");
    init_bound_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R3]
        state_q == ST_INIT |-> cnt_q < tx_safety_pkg::CNT_W'(INIT_CYCLES))
        else $error("Initialization count beyond its limit");

endmodule

// >>> design/tx_safety_pkg.sv
// Constants for the transmitter safety and control pin block.
// Assumes a single 100 MHz system clock and asynchronous pin inputs.
//
// What this block is required to do
// R1 - Rising transmit-off drops laser output below ten percent within 10 us.
// R2 - Falling transmit-off restores laser output above ninety percent within 1 ms.
// R3 - Driver output stable within 300 ms of power-on or fault clear.
// R4 - Fault indicator goes high within 100 us of a fault.
// R5 - A 10 us transmit-off high pulse initializes safety logic, clears latched fault. The code reinitializes only from the fault state.
// R6 - Power-down is entered within 100 us of its initiation.
// R7 - Host holds power-down/reset at least 10 us to start a reset.
// R8 - Power-down/reset held high keeps standby; low means normal operation.
// R9 - Falling power-down/reset edge starts a full device reset like power-on.
// R10 - Transmit-off high or floating switches off bias and modulation.
// R11 - Serial port select high picks SPI, low or floating picks 2-wire.
// R12 - Shared host pins are clock/data in 2-wire, data out/in in SPI.
// R13 - Cathode select high means common cathode, low or floating common anode. The code ignores cathode select.
// R14 - Anode wiring uses supply switch; cathode wiring uses ground switch. The code drives both switches with the laser drive in either wiring.
// R15 - Control inputs are synchronized; pulse widths counted on the internal clock.
package tx_safety_pkg;

    // -------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------
    localparam int CLK_MHZ        = 100;
    localparam int T_OFF_US       = 10;
    localparam int T_ON_US        = 1000;
    localparam int T_INIT_MS      = 300;
    localparam int T_FAULT_US     = 100;
    localparam int T_RESET_US     = 10;
    localparam int T_PDOWN_US     = 100;
    localparam int T_PDRST_US     = 10;
    // Least widths round up; none are fractional at 100 MHz
    localparam int RESET_CYCLES   = T_RESET_US * CLK_MHZ;
    localparam int PDRST_CYCLES   = T_PDRST_US * CLK_MHZ;
    localparam int INIT_CYCLES    = T_INIT_MS * 1000 * CLK_MHZ;
    // Internal settle time before output is declared stable (well under limit)
    localparam int SETTLE_US      = 100;
    localparam int SETTLE_CYCLES  = SETTLE_US * CLK_MHZ;
    localparam int CNT_W          = 25;

    typedef enum logic [1:0] {
        ST_INIT,
        ST_RUN,
        ST_FAULT,
        ST_PDOWN
    } state_e;

endpackage

// >>> tb/host_pins_model.sv
// Host controller model: drives the module's transmit-off and power-down pins.
// Assumes the bench calls drive() from one process synced to clk_sys.
`timescale 1ns/1ps
module host_pins_model (
    input  wire logic clk_sys,
    output logic      transmit_off_request,
    output logic      power_down_request
);
    // Both pins start low so the module comes up in normal operation
    initial begin
        transmit_off_request = 1'b0;
        power_down_request   = 1'b0;
    end
    // Pins change only just after a rising edge; the caller sets the width.
    // Returns at the next falling edge so the caller sees the new level.
    task automatic drive(input bit pd, input logic lvl);
        @(posedge clk_sys);
        if (pd) begin
            power_down_request <= lvl;
        end else begin
            transmit_off_request <= lvl;
        end
        @(negedge clk_sys);
    endtask
endmodule

// >>> tb/transmit_safety_control_pins_tb.sv
// Self-checking bench for the transmit safety control block.
// Assumes a 100 MHz clock and a shortened settle count.
`timescale 1ns/1ps
module transmit_safety_control_pins_tb;
    localparam int SETTLE = 20;
    logic        clk_sys, reset_n, fault_detect, serial_port_select, cathode_select;
    logic        spi_data_out, spi_data_out_en, two_wire_data_out_en, pin_a_in, pin_b_in;
    logic        txoff, pdreq, a_out, a_oe, b_out, b_oe, spi_mode, bias_en, mod_en;
    logic        sup_sw, gnd_sw, fault_oe, power_down, init_reset, output_stable;
    logic        tw_clk, tw_dat, spi_din, f_out, freeze;
    logic [31:0] rng = 32'h0001_1656;
    int          err_count, cmp_count, cycles, faults;

    host_pins_model u_host_pins_model (.clk_sys(clk_sys), .transmit_off_request(txoff),
        .power_down_request(pdreq));
    tx_safety_ctrl #(.SETTLE_CYCLES(SETTLE)) u_tx_safety_ctrl (.clk_sys(clk_sys),
        .reset_n(reset_n), .clk_en(1'b1), .transmit_off_request(txoff),
        .power_down_request(pdreq), .serial_port_select(serial_port_select),
        .cathode_select(cathode_select), .fault_detect(fault_detect),
        .spi_data_out(spi_data_out), .spi_data_out_en(spi_data_out_en),
        .two_wire_data_out_en(two_wire_data_out_en), .host_link_pin_a_in(pin_a_in),
        .host_link_pin_b_in(pin_b_in), .host_link_pin_a_out(a_out), .host_link_pin_a_oe(a_oe),
        .host_link_pin_b_out(b_out), .host_link_pin_b_oe(b_oe), .two_wire_clock(tw_clk),
        .two_wire_data(tw_dat), .spi_data_in(spi_din), .spi_mode(spi_mode),
        .bias_enable(bias_en),
        .modulation_enable(mod_en), .supply_switch_or_cathode_bias(sup_sw),
        .anode_bias_or_ground_switch(gnd_sw), .fault_out(f_out), .fault_oe(fault_oe),
        .power_down(power_down), .init_reset(init_reset), .output_stable(output_stable));

    // Clock, 10 ns period
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    // Reference: laser drive only with both pins low and no latched fault
    function automatic logic exp_drive();
        return !txoff && !pdreq && faults == 0;
    endfunction
    function automatic logic pick(input int k);
        case (k)
            0: return bias_en;
            1: return fault_oe;
            2: return power_down;
            default: return output_stable;
        endcase
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Bounded wait on a watched output, then compare
    task automatic await(input int k, input logic v, input int lim);
        int n;
        n = 0;
        while (pick(k) !== v && n < lim) begin
            @(negedge clk_sys);
            n++;
        end
        chk(pick(k), v);
    endtask
    task automatic hold(input bit pd, input int n);
        u_host_pins_model.drive(pd, 1'b1);
        repeat (n) @(negedge clk_sys);
        u_host_pins_model.drive(pd, 1'b0);
        @(negedge clk_sys);
    endtask
    task automatic print_verdict();
        $display("counts cmp=%0d err=%0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Random engine-side inputs each cycle; cycle ceiling cuts a hang short
    always @(posedge clk_sys) begin
        rng = xs(rng);
        {spi_data_out, spi_data_out_en, two_wire_data_out_en} <= rng[2:0];
        // Host pins held still while a routing check looks at them
        if (!freeze) begin
            {pin_a_in, pin_b_in} <= rng[4:3];
        end
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            print_verdict();
        end
    end

    initial begin
        logic s, c;
        reset_n = 1'b0;
        fault_detect = 1'b0;
        serial_port_select = 1'b0;
        cathode_select = 1'b0;
        freeze = 1'b0;
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        await(3, 1'b1, SETTLE + 40);
        await(0, exp_drive(), 10);
        chk({mod_en, fault_oe, f_out}, 8'h06);
        $display("test power_on done");
        u_host_pins_model.drive(0, 1'b1);
        await(0, exp_drive(), 1000);
        chk(mod_en, 8'h00);
        u_host_pins_model.drive(0, 1'b0);
        await(0, exp_drive(), 1000);
        $display("test transmit_off done");
        @(posedge clk_sys);
        fault_detect <= 1'b1;
        faults = 1;
        @(posedge clk_sys);
        fault_detect <= 1'b0;
        await(1, 1'b0, 10000);
        await(0, exp_drive(), 20);
        hold(0, 200);
        repeat (20) @(negedge clk_sys);
        chk({fault_oe, bias_en}, 8'h00);
        hold(0, 1050);
        faults = 0;
        await(1, 1'b1, SETTLE + 40);
        await(3, 1'b1, SETTLE + 40);
        await(0, exp_drive(), 10);
        $display("test fault_clear done");
        hold(1, 200);
        chk(power_down, 8'h00);
        u_host_pins_model.drive(1, 1'b1);
        await(2, 1'b1, 10000);
        repeat (50) @(negedge clk_sys);
        chk({power_down, bias_en, init_reset}, 8'h05);
        u_host_pins_model.drive(1, 1'b0);
        await(2, 1'b0, 10);
        await(3, 1'b1, SETTLE + 40);
        $display("test power_down done");
        // Random select pins, routing compared against the reference
        for (int i = 0; i < 24; i++) begin
            @(negedge clk_sys);
            {s, c} = rng[6:5];
            @(posedge clk_sys);
            serial_port_select <= s;
            cathode_select <= c;
            freeze <= 1'b1;
            repeat (8) @(negedge clk_sys);
            chk(spi_mode, s);
            chk({a_oe, b_oe}, s ? {spi_data_out_en, 1'b0} : {1'b0, two_wire_data_out_en});
            chk({a_out, b_out}, s ? {spi_data_out, 1'b0} : 2'b00);
            chk({tw_clk, tw_dat, spi_din},
                s ? {2'b11, pin_b_in} : {pin_a_in, pin_b_in, 1'b0});
            chk({sup_sw, gnd_sw}, {2{exp_drive()}});
            @(posedge clk_sys);
            freeze <= 1'b0;
        end
        $display("test pin_select done");
        print_verdict();
    end
endmodule
